// ===== verilog/gaem_pkg.sv
// Package of offsets, field positions and constants for the address and end-string block.
package gaem_pkg;
   // ==========================================================================
   // Register offsets
   localparam logic [8:0] OFS_ADDR_LOAD = 9'h11d;
   localparam logic [8:0] OFS_SEC_READ_EOS = 9'h11f;
   // ==========================================================================
   // Address load and secondary readback field positions
   localparam int BIT_BANK_SEL = 7;
   localparam int BIT_DIS_TALK = 6;
   localparam int BIT_DIS_LISTEN = 5;
   localparam int BIT_EOI_READ = 7;
   // ==========================================================================
   // Bus code offsets
   localparam logic [7:0] TALK_BASE = 8'h40;
   localparam logic [7:0] LISTEN_BASE = 8'h20;
   localparam logic [7:0] SECONDARY_BASE = 8'ha0;
   // ==========================================================================
   // Reset values
   localparam logic [6:0] ADDR_STORE_RESET = 7'h00;
   localparam logic [7:0] EOS_RESET = 8'h00;
   // ==========================================================================
   // Addressing modes
   typedef enum logic [1:0] {
      GAEM_MODE_NONE,
      GAEM_MODE_DUAL1,
      GAEM_MODE_SECOND,
      GAEM_MODE_DUAL3
   } gaem_mode_t;
endpackage

// ===== verilog/gaem_eos_cmp.sv
// End-of-string byte comparator with seven or eight bit width.
`timescale 1ns/1ns
`default_nettype none
module gaem_eos_cmp (
   // Operands
   input wire logic [7:0] i_data,
   input wire logic [7:0] i_pattern,
   input wire logic i_eight_bit,
   // Result
   output logic o_match
);
   always_comb begin
      // Bit 7 is masked out of both sides in seven-bit mode.
      o_match = (i_data[6:0] == i_pattern[6:0]) &&
                (!i_eight_bit || (i_data[7] == i_pattern[7])); // see [RL19]
   end
endmodule
`default_nettype wire

// ===== verilog/gaem_top.sv
// Address recognition and end-of-string detection for the talker/listener core.
// Function
// [RL1] Bit 7 picks primary or secondary store
// [RL2] Software loads both stores in every mode
// [RL3] Talk disable blocks own talk address
// [RL4] Listen disable blocks own listen address
// [RL5] Talk is field+40, listen field+20
// [RL6] Software never writes all-ones address field
// [RL7] Secondary store holds secondary or minor address
// [RL8] Mode 1 single address disables secondary; the code treats mode 1 as dual, with the secondary store as minor address
// [RL9] Mode 2 secondary disables copy primary
// [RL10] Readback bit 7 latches EOI, reset clears
// [RL11] Secondary talk checked only after primary talk
// [RL12] Secondary listen checked after primary listen
// [RL13] Secondary address is field plus A0
// [RL14] Minor talk +40, minor listen +20
// [RL15] Eight-bit pattern, width chosen by config
// [RL16] Listener match sets end flag
// [RL17] Talker match drives EOI low
// [RL18] Primary readback shares load port offset
// [RL19] Seven-bit mode ignores bit 7
`timescale 1ns/1ns
`default_nettype none
module gaem_top (
   // Clock and reset
   input wire logic I_CLOCK,
   input wire logic I_ARST_N,
   // Register port
   input wire logic [8:0] I_REG_ADDR,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [7:0] I_REG_WDATA,
   output logic [7:0] O_REG_RDATA,
   // Configuration from the core
   input wire logic [1:0] I_ADDR_MODE,
   input wire logic I_COMPARE_WIDTH_SELECT,
   input wire logic I_RECEIVE_END_MATCH_ENABLE,
   input wire logic I_TRANSMIT_END_MATCH_ENABLE,
   input wire logic I_CHIP_RESET_CMD,
   // Bus side: command and data bytes
   input wire logic I_CMD_VALID,
   input wire logic [7:0] I_CMD_BYTE,
   input wire logic I_UNADDRESS,
   input wire logic I_DATA_ACCEPT,
   input wire logic [7:0] I_DATA_BYTE,
   input wire logic I_EOI_LINE,
   input wire logic I_DATA_SEND,
   input wire logic [7:0] I_OUTGOING_DATA_BYTE,
   // Status
   output logic O_TALK_ADDRESSED,
   output logic O_LISTEN_ADDRESSED,
   output logic O_END_FLAG_SET,
   output logic O_EOI_N_OUT,
   output logic O_EOI_N_OE
);
   // ==========================================================================
   // Stores
   logic [6:0] prim_q, prim_d;
   logic [6:0] sec_q, sec_d;
   logic [7:0] eos_q, eos_d;
   logic eoi_q, eoi_d;
   logic tpas_q, tpas_d;
   logic lpas_q, lpas_d;
   logic talk_q, talk_d;
   logic listen_q, listen_d;
   logic endf_q, endf_d;
   logic [7:0] rdata_q, rdata_d;
   logic rx_match;
   logic tx_match;
   logic dual;
   logic wr_addr;
   logic wr_eos;

   assign dual = (I_ADDR_MODE == gaem_pkg::GAEM_MODE_DUAL1) ||
                 (I_ADDR_MODE == gaem_pkg::GAEM_MODE_DUAL3); // see [RL7]
   assign wr_addr = I_REG_WR && (I_REG_ADDR == gaem_pkg::OFS_ADDR_LOAD);
   assign wr_eos = I_REG_WR && (I_REG_ADDR == gaem_pkg::OFS_SEC_READ_EOS);

   function automatic logic [7:0] code_of(input logic [6:0] store, input logic [7:0] base);
      code_of = base + {3'h0, store[4:0]};
   endfunction

   // ==========================================================================
   // Register writes and readback
   always_comb begin
      prim_d = prim_q;
      sec_d = sec_q;
      eos_d = eos_q;
      if (wr_addr) begin
         if (I_REG_WDATA[gaem_pkg::BIT_BANK_SEL]) begin
            sec_d = I_REG_WDATA[6:0]; // see [RL1]
         end else begin
            prim_d = I_REG_WDATA[6:0]; // see [RL1]
         end
      end
      if (wr_eos) begin
         eos_d = I_REG_WDATA; // see [RL15]
      end
      rdata_d = 8'h00;
      if (I_REG_RD && (I_REG_ADDR == gaem_pkg::OFS_ADDR_LOAD)) begin
         rdata_d = {1'b0, prim_q}; // see [RL18]
      end else if (I_REG_RD && (I_REG_ADDR == gaem_pkg::OFS_SEC_READ_EOS)) begin
         rdata_d = {eoi_q, sec_q}; // see [RL10]
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         prim_q <= gaem_pkg::ADDR_STORE_RESET;
         sec_q <= gaem_pkg::ADDR_STORE_RESET;
         eos_q <= gaem_pkg::EOS_RESET;
         rdata_q <= 8'h00;
      end else begin
         prim_q <= prim_d;
         sec_q <= sec_d;
         eos_q <= eos_d;
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================================
   // Address recognition
   always_comb begin
      tpas_d = tpas_q;
      lpas_d = lpas_q;
      talk_d = talk_q;
      listen_d = listen_q;
      if (I_UNADDRESS) begin
         tpas_d = 1'b0;
         lpas_d = 1'b0;
         talk_d = 1'b0;
         listen_d = 1'b0;
      end else if (I_CMD_VALID) begin
         // A fresh primary command ends any pending secondary wait.
         if (I_CMD_BYTE[7:5] != 3'b101) begin
            tpas_d = 1'b0;
            lpas_d = 1'b0;
         end
         if (!prim_q[gaem_pkg::BIT_DIS_TALK] &&
             I_CMD_BYTE == code_of(prim_q, gaem_pkg::TALK_BASE)) begin // see [RL3] [RL5]
            if (dual) begin
               talk_d = 1'b1;
            end else begin
               tpas_d = 1'b1;
            end
         end
         if (!prim_q[gaem_pkg::BIT_DIS_LISTEN] &&
             I_CMD_BYTE == code_of(prim_q, gaem_pkg::LISTEN_BASE)) begin // see [RL4] [RL5]
            if (dual) begin
               listen_d = 1'b1;
            end else begin
               lpas_d = 1'b1;
            end
         end
         if (dual && !sec_q[gaem_pkg::BIT_DIS_TALK] &&
             I_CMD_BYTE == code_of(sec_q, gaem_pkg::TALK_BASE)) begin // see [RL14]
            talk_d = 1'b1;
         end
         if (dual && !sec_q[gaem_pkg::BIT_DIS_LISTEN] &&
             I_CMD_BYTE == code_of(sec_q, gaem_pkg::LISTEN_BASE)) begin // see [RL14]
            listen_d = 1'b1;
         end
         if (!dual && I_CMD_BYTE == code_of(sec_q, gaem_pkg::SECONDARY_BASE)) begin // see [RL13]
            if (tpas_q && !sec_q[gaem_pkg::BIT_DIS_TALK]) begin // see [RL11]
               talk_d = 1'b1;
            end
            if (lpas_q && !sec_q[gaem_pkg::BIT_DIS_LISTEN]) begin // see [RL12]
               listen_d = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tpas_q <= 1'b0;
         lpas_q <= 1'b0;
         talk_q <= 1'b0;
         listen_q <= 1'b0;
      end else begin
         tpas_q <= tpas_d;
         lpas_q <= lpas_d;
         talk_q <= talk_d;
         listen_q <= listen_d;
      end
   end

   // ==========================================================================
   // End-of-string and EOI
   gaem_eos_cmp u_rx_cmp (
      .i_data(I_DATA_BYTE),
      .i_pattern(eos_q),
      .i_eight_bit(I_COMPARE_WIDTH_SELECT),
      .o_match(rx_match)
   );
   gaem_eos_cmp u_tx_cmp (
      .i_data(I_OUTGOING_DATA_BYTE),
      .i_pattern(eos_q),
      .i_eight_bit(I_COMPARE_WIDTH_SELECT),
      .o_match(tx_match)
   );

   always_comb begin
      eoi_d = eoi_q;
      // A byte accepted in the reset-command cycle still latches its EOI.
      if (I_CHIP_RESET_CMD) begin
         eoi_d = 1'b0;
      end
      if (I_DATA_ACCEPT) begin
         eoi_d = I_EOI_LINE; // see [RL10]
      end
      endf_d = I_DATA_ACCEPT && listen_q && I_RECEIVE_END_MATCH_ENABLE && rx_match; // see [RL16]
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         eoi_q <= 1'b0;
         endf_q <= 1'b0;
      end else begin
         eoi_q <= eoi_d;
         endf_q <= endf_d;
      end
   end

   // EOI is open drain: enable low while pulling the line low.
   always_comb begin
      O_EOI_N_OUT = 1'b0;
      O_EOI_N_OE = !(I_DATA_SEND && talk_q && I_TRANSMIT_END_MATCH_ENABLE && tx_match); // see [RL17]
   end

   assign O_REG_RDATA = rdata_q;
   assign O_TALK_ADDRESSED = talk_q;
   assign O_LISTEN_ADDRESSED = listen_q;
   assign O_END_FLAG_SET = endf_q;

   // ==========================================================================
   // Checks
   sequence s_accept_eoi;
      I_DATA_ACCEPT && I_EOI_LINE;
   endsequence
   AST_EOI_LATCH: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      s_accept_eoi |=> eoi_q) else $error("EOI not latched"); // see [RL10]
   AST_EOI_CLEAR: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      I_CHIP_RESET_CMD && !I_DATA_ACCEPT |=> !eoi_q) else $error("EOI not cleared"); // see [RL10]
   AST_PRIM_LOAD: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      wr_addr && !I_REG_WDATA[7] |=> prim_q == $past(I_REG_WDATA[6:0])) else $error("prim"); // see [RL1]
   AST_SEC_LOAD: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      wr_addr && I_REG_WDATA[7] |=> sec_q == $past(I_REG_WDATA[6:0]) && $stable(prim_q))
      else $error("sec"); // see [RL1]
   AST_NO_TALK_DIS: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      !talk_q && I_CMD_VALID && dual && prim_q[6] && sec_q[6] |=> !talk_q)
      else $error("disabled talker addressed"); // see [RL3]
   AST_NO_LISTEN_DIS: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      !listen_q && I_CMD_VALID && dual && prim_q[5] && sec_q[5] |=> !listen_q)
      else $error("disabled listener addressed"); // see [RL4]
   AST_TALK_CODE: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      I_CMD_VALID && !I_UNADDRESS && dual && !prim_q[6] &&
      I_CMD_BYTE == {3'b010, prim_q[4:0]} |=> talk_q) else $error("talk code"); // see [RL5]
   AST_SEC_NEEDS_TPAS: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      !talk_q && !tpas_q && I_CMD_VALID && !dual && I_CMD_BYTE[7:5] == 3'b101 |=> !talk_q)
      else $error("secondary without primary"); // see [RL11]
   AST_END_FLAG: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      O_END_FLAG_SET |-> $past(listen_q && I_RECEIVE_END_MATCH_ENABLE && I_DATA_ACCEPT))
      else $error("end flag cause"); // see [RL16]
   AST_EOI_DRIVE: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
      !O_EOI_N_OE |-> talk_q && I_TRANSMIT_END_MATCH_ENABLE &&
      I_OUTGOING_DATA_BYTE[6:0] == eos_q[6:0]) else $error("EOI drive"); // see [RL17]
endmodule
`default_nettype wire

// ===== tb/gaem_bus_model.sv
// Behavioural model of the instrument bus controller feeding the block.
`timescale 1ns/1ns
`default_nettype none
module gaem_bus_model (
   // Clock
   input wire logic clk,
   // Bus traffic
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic unaddress,
   output logic data_accept,
   output logic [7:0] data_byte,
   output logic eoi_line,
   output logic data_send,
   output logic [7:0] out_byte
);
   // ==========
   // Idle state
   initial begin
      {cmd_valid, unaddress, data_accept, eoi_line, data_send} = 5'h00;
      {cmd_byte, data_byte, out_byte} = {8'h5a, 8'ha5, 8'h3c};
   end
   // Released bytes flip so that a stale value can never pass for a fresh one.
   task automatic cmd(input logic [7:0] b);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_byte <= b;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_byte <= ~b;
   endtask
   task automatic unaddr();
      @(posedge clk);
      unaddress <= 1'b1;
      @(posedge clk);
      unaddress <= 1'b0;
   endtask
   task automatic accept(input logic [7:0] b, input logic e);
      @(posedge clk);
      data_accept <= 1'b1;
      data_byte <= b;
      eoi_line <= e;
      @(posedge clk);
      data_accept <= 1'b0;
      data_byte <= ~b;
      eoi_line <= 1'b0;
   endtask
   task automatic send(input logic on, input logic [7:0] b);
      @(posedge clk);
      data_send <= on;
      out_byte <= b;
   endtask
endmodule
`default_nettype wire

// ===== tb/gaem_top_bench.sv
// Self-checking bench for address recognition and end-string matching.
`timescale 1ns/1ns
`default_nettype none
module gaem_top_bench;
   logic clk, arst_n, wr, rd, wsel, ren, ten, crst;
   logic cv, ua, da, eoi, ds, talk, lis, endf, eoi_o, eoi_oe;
   logic [8:0] addr;
   logic [7:0] wdata, rdata, cb, db, ob, v;
   logic [1:0] mode;
   int n_fail, n_compared;
   gaem_top gaem_top_inst (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_REG_ADDR(addr),
      .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
      .I_ADDR_MODE(mode), .I_COMPARE_WIDTH_SELECT(wsel),
      .I_RECEIVE_END_MATCH_ENABLE(ren), .I_TRANSMIT_END_MATCH_ENABLE(ten),
      .I_CHIP_RESET_CMD(crst), .I_CMD_VALID(cv), .I_CMD_BYTE(cb), .I_UNADDRESS(ua),
      .I_DATA_ACCEPT(da), .I_DATA_BYTE(db), .I_EOI_LINE(eoi), .I_DATA_SEND(ds),
      .I_OUTGOING_DATA_BYTE(ob), .O_TALK_ADDRESSED(talk), .O_LISTEN_ADDRESSED(lis),
      .O_END_FLAG_SET(endf), .O_EOI_N_OUT(eoi_o), .O_EOI_N_OE(eoi_oe));
   gaem_bus_model gaem_bus_model_inst (.clk(clk), .cmd_valid(cv), .cmd_byte(cb),
      .unaddress(ua), .data_accept(da), .data_byte(db), .eoi_line(eoi),
      .data_send(ds), .out_byte(ob));
   // ==========
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wreg(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk);
      {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [8:0] a);
      @(posedge clk);
      {rd, addr} <= {1'b1, a};
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic cmd_st(input logic [7:0] b, input logic t, input logic l);
      gaem_bus_model_inst.cmd(b);
      #1 chk({6'h00, talk, lis}, {6'h00, t, l});
   endtask
   // ==========
   // Scenarios
   task automatic s_regs();
      wreg(9'h11d, 8'h03);
      wreg(9'h11d, 8'h85);
      rreg(9'h11d);
      chk(v, 8'h03);
      rreg(9'h11f);
      chk(v, 8'h05);
      rreg(9'h100);
      chk(v, 8'h00);
   endtask
   task automatic s_dual();
      @(posedge clk) mode <= 2'h1;
      cmd_st(8'h43, 1'b1, 1'b0);
      gaem_bus_model_inst.unaddr();
      cmd_st(8'h25, 1'b0, 1'b1);
      cmd_st(8'h45, 1'b1, 1'b1);
      gaem_bus_model_inst.unaddr();
   endtask
   task automatic s_dis();
      wreg(9'h11d, 8'h63);
      wreg(9'h11d, 8'he5);
      cmd_st(8'h43, 1'b0, 1'b0);
      cmd_st(8'h23, 1'b0, 1'b0);
      cmd_st(8'h45, 1'b0, 1'b0);
      cmd_st(8'h25, 1'b0, 1'b0);
      wreg(9'h11d, 8'h03);
      wreg(9'h11d, 8'h85);
   endtask
   task automatic s_sec();
      @(posedge clk) mode <= 2'h2;
      cmd_st(8'ha5, 1'b0, 1'b0);
      gaem_bus_model_inst.cmd(8'h43);
      cmd_st(8'ha5, 1'b1, 1'b0);
      gaem_bus_model_inst.unaddr();
      gaem_bus_model_inst.cmd(8'h23);
      cmd_st(8'ha5, 1'b0, 1'b1);
   endtask
   task automatic s_eos();
      wreg(9'h11f, 8'h8a);
      @(posedge clk) {ren, wsel} <= 2'b10;
      gaem_bus_model_inst.accept(8'h0a, 1'b1);
      #1 chk({7'h00, endf}, 8'h01);
      rreg(9'h11f);
      chk(v, 8'h85);
      @(posedge clk) wsel <= 1'b1;
      gaem_bus_model_inst.accept(8'h0a, 1'b0);
      #1 chk({7'h00, endf}, 8'h00);
      gaem_bus_model_inst.accept(8'h8a, 1'b1);
      #1 chk({7'h00, endf}, 8'h01);
      @(posedge clk) crst <= 1'b1;
      @(posedge clk) crst <= 1'b0;
      rreg(9'h11f);
      chk(v, 8'h05);
      gaem_bus_model_inst.unaddr();
      // Mode 2 needs the secondary after the primary talk code to become a talker.
      gaem_bus_model_inst.cmd(8'h43);
      cmd_st(8'ha5, 1'b1, 1'b0);
      @(posedge clk) ten <= 1'b1;
      gaem_bus_model_inst.send(1'b1, 8'h8a);
      #1 chk({6'h00, eoi_o, eoi_oe}, 8'h00);
      gaem_bus_model_inst.send(1'b1, 8'h0a);
      #1 chk({6'h00, eoi_o, eoi_oe}, 8'h01);
      gaem_bus_model_inst.send(1'b0, 8'h0a);
   endtask
   // ==========
   // Run
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {arst_n, wr, rd, wsel, ren, ten, crst} = 7'h00;
      {addr, wdata, mode} = {9'h000, 8'h00, 2'h0};
      n_fail = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      chk({4'h0, talk, lis, endf, eoi_oe}, 8'h01);
      chk(rdata, 8'h00);
      arst_n <= 1'b1;
      s_regs();
      s_dual();
      s_dis();
      s_sec();
      s_eos();
      results();
   end
endmodule
`default_nettype wire
